// ### css_top.sv
// What this block does
// - Repeat count only for host-advanced scans.
// - Continuous bit: one repeats, zero stops.
// - Scan closes one channel, or a pair in four-wire, break first.
// - Four trigger sources: external, bus, handshake, self.
// - Bus source: scan_a or trigger advances.
// - Channels 0-7 bank zero, 8-15 bank one.
// - No-port routing opens both tree switches.
// - Reset leaves routing no-port, trees open.
// - Analog bus routing joins both trees, bus.
// - One closed channel, two in four-wire.
// - Closing opens the old channel first.
// - Closed query one means closed; open inverts.
// - Range query gives per-channel values in order.
// - Unread query answer then command flags error.
// - A tree sense lines, B tree source lines.
// - Four-wire separates banks, source via B.
// - Four-wire also closes partner eight away.
// - Handshake source advances on meter completion.
// - Trigger out only for external or bus.
// - Advance only from the selected source.
// - Scan_a closes the first list entry.
// - Handshake or self source runs from local list.
// - After last entry wrap, repeat per count.
//
// Strobed register access and the register offsets were left to the implementer.
`default_nettype none
module css_top
  import css_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int LIST_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Meter and mainframe pins
  input wire logic ext_event,
  input wire logic meas_done,
  output logic trig_out,
  output logic meter_trig,
  // Switch drive
  output logic [CHANNELS-1:0] chan_close,
  output logic tree_a_close,
  output logic tree_b_close,
  output logic tree_a_bank,
  output logic tree_b_bank,
  output logic bank_isolate,
  output logic scan_done
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } css_state_type;

  css_trig_if tif ();

  css_state_type state_q, state_d;
  logic [5:0] ctrl_q, ctrl_d;
  logic [15:0] arm_q, arm_d;
  logic [4:0] len_q, len_d;
  logic [3:0] list_q [LIST_DEPTH];
  logic [3:0] list_d [LIST_DEPTH];
  logic [3:0] ptr_q, ptr_d;
  logic [15:0] cyc_q, cyc_d;
  logic [3:0] sel_q, sel_d;
  logic [CHANNELS-1:0] target_q, target_d;
  logic [CHANNELS-1:0] result_q, result_d;
  logic done_q, done_d, err_q, err_d, pend_q, pend_d;
  logic tree_a_q, tree_a_d, tree_b_q, tree_b_d;
  logic a_bank_q, a_bank_d, b_bank_q, b_bank_d, iso_q, iso_d;
  logic [31:0] rdata_q, rdata_d;
  logic busy, settled;
  logic wr_cmd, go, downloaded, last_entry, last_cycle;
  logic [3:0] nptr, chan_arg;
  logic [15:0] ncyc, arm_eff;
  logic [4:0] q_idx;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [CHANNELS-1:0] close_mask(input logic [3:0] ch,
                                                     input logic four_wire_resistance_mode);
    logic [CHANNELS-1:0] m;
    m = '0;
    m[ch] = 1'b1;
    if (four_wire_resistance_mode) begin
      m[ch ^ 4'h8] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  css_break_make #(
    .CHANNELS(CHANNELS)
  ) u_bbm (
    .clk(clk),
    .rst(rst),
    .target(target_q),
    .applied(chan_close),
    .busy(busy),
    .settled(settled)
  );

  css_trig_unit u_trig (
    .clk(clk),
    .rst(rst),
    .tif(tif.unit),
    .ext_event(ext_event),
    .meas_done(meas_done),
    .trig_out(trig_out),
    .meter_trig(meter_trig)
  );

  assign tif.src = ctrl_q[CTRL_SRC_LSB +: 2];
  assign tif.trig_out_en = ctrl_q[CTRL_TOUT];
  assign tif.armed = (state_q == ST_RUN) && !busy;
  assign tif.settled = settled;
  assign wr_cmd = wr && hit(addr, ADDR_CMD);
  assign chan_arg = wdata[CMD_CHAN_LSB +: 4];
  // Scan_a or trigger while running advances on the bus source.
  assign tif.sw_trig = wr_cmd && (wdata[CMD_TRIG] ||
                       (wdata[CMD_INIT] && state_q == ST_RUN));

  // ----------------------------------------------------------------------
  // Registers, scan engine and queries
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    arm_d = arm_q;
    len_d = len_q;
    list_d = list_q;
    ptr_d = ptr_q;
    cyc_d = cyc_q;
    sel_d = sel_q;
    target_d = target_q;
    result_d = result_q;
    done_d = done_q;
    err_d = err_q;
    pend_d = pend_q;
    rdata_d = 32'h0000_0000;
    q_idx = 5'h00;
    downloaded = (tif.src == SRC_HANDSHAKE_BUS_SOURCE) || (tif.src == SRC_IMM);
    arm_eff = (arm_q == 16'h0000) ? 16'h0001 : arm_q;
    go = 1'b0;
    nptr = 4'h0;
    ncyc = 16'h0000;
    if (wr) begin
      if (hit(addr, ADDR_CTRL)) begin
        ctrl_d = wdata[5:0];
      end
      if (hit(addr, ADDR_ARM)) begin
        arm_d = wdata[15:0];
      end
      if (hit(addr, ADDR_LEN)) begin
        if (wdata[4:0] == 5'h00) begin
          len_d = 5'h01;
        end else if (wdata[4:0] > 5'(LIST_DEPTH)) begin
          len_d = 5'(LIST_DEPTH);
        end else begin
          len_d = wdata[4:0];
        end
      end
      if (addr[7:6] == LIST_PAGE) begin
        list_d[addr[5:2]] = wdata[3:0];
      end
      if (hit(addr, ADDR_QUERY)) begin
        for (int i = 0; i < CHANNELS; i++) begin
          q_idx = 5'(wdata[QRY_START_LSB +: 4]) + 5'(i);
          result_d[i] = 1'b0;
          if (q_idx <= 5'(wdata[QRY_END_LSB +: 4])) begin
            result_d[i] = target_q[q_idx[3:0]] ^ wdata[QRY_OPEN];
          end
        end
        pend_d = 1'b1;
      end
      if (hit(addr, ADDR_STATUS) && wdata[STAT_ERR]) begin
        err_d = 1'b0;
      end
    end
    if (wr_cmd) begin
      if (wdata[CMD_CLOSE]) begin
        target_d = close_mask(chan_arg, ctrl_q[CTRL_FOUR_WIRE_RESISTANCE_MODE]);
        sel_d = chan_arg;
        state_d = ST_IDLE;
      end else if (wdata[CMD_OPEN]) begin
        if (target_q[chan_arg]) begin
          target_d = '0;
        end
        state_d = ST_IDLE;
      end else if (wdata[CMD_INIT] && state_q != ST_RUN) begin
        go = 1'b1;
        done_d = 1'b0;
        state_d = ST_RUN;
      end
    end
    if (rd && hit(addr, ADDR_RESULT)) begin
      pend_d = 1'b0;
    end
    // An unread answer followed by a command is an error; set beats clear.
    if (pend_q && wr && (hit(addr, ADDR_CMD) || hit(addr, ADDR_QUERY) ||
                         hit(addr, ADDR_CTRL))) begin
      err_d = 1'b1;
    end
    last_entry = (5'(ptr_q) + 5'h01 >= len_q);
    if (tif.advance && !go && state_d == ST_RUN) begin
      go = 1'b1;
      nptr = last_entry ? 4'h0 : ptr_q + 4'h1;
      ncyc = (last_entry && !ctrl_q[CTRL_CONT]) ? cyc_q + 16'h0001 : cyc_q;
    end
    // Host-advanced scans honour the count; local lists run once or forever.
    last_cycle = !ctrl_q[CTRL_CONT] &&
                 (downloaded || (17'(ncyc) + 17'h00001 >= 17'(arm_eff)));
    if (go) begin
      ptr_d = nptr;
      cyc_d = ncyc;
      sel_d = list_q[nptr];
      target_d = close_mask(list_q[nptr], ctrl_q[CTRL_FOUR_WIRE_RESISTANCE_MODE]);
      if (5'(nptr) + 5'h01 >= len_q && last_cycle) begin
        state_d = ST_DONE;
        done_d = 1'b1;
      end
    end
    if (rd) begin
      case (addr)
        ADDR_CTRL: rdata_d = {26'h000_0000, ctrl_q};
        ADDR_ARM: rdata_d = {16'h0000, arm_q};
        ADDR_LEN: rdata_d = {27'h000_0000, len_q};
        ADDR_RESULT: rdata_d = {16'h0000, result_q};
        ADDR_STATUS: begin
          rdata_d[STAT_RUN] = (state_q == ST_RUN);
          rdata_d[STAT_DONE] = done_q;
          rdata_d[STAT_ERR] = err_q;
          rdata_d[STAT_PEND] = pend_q;
          rdata_d[STAT_BUSY] = busy;
          rdata_d[STAT_CHAN_LSB +: 4] = sel_q;
          rdata_d[STAT_CLOSED_LSB +: 16] = chan_close;
        end
        default: begin
          if (addr[7:6] == LIST_PAGE) begin
            rdata_d = {28'h000_0000, list_q[addr[5:2]]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Tree isolation and bank routing
  // ----------------------------------------------------------------------
  always_comb begin
    tree_a_d = ctrl_q[CTRL_ANALOG_BUS_ROUTING];
    tree_b_d = ctrl_q[CTRL_ANALOG_BUS_ROUTING];
    a_bank_d = sel_q[3];
    b_bank_d = ctrl_q[CTRL_FOUR_WIRE_RESISTANCE_MODE] ? !sel_q[3] : sel_q[3];
    iso_d = ctrl_q[CTRL_FOUR_WIRE_RESISTANCE_MODE];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ctrl_q <= CTRL_RST;
      arm_q <= ARM_RST;
      len_q <= LEN_RST;
      for (int i = 0; i < LIST_DEPTH; i++) begin
        list_q[i] <= 4'(i);
      end
      ptr_q <= 4'h0;
      cyc_q <= 16'h0000;
      sel_q <= 4'h0;
      target_q <= '0;
      result_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      pend_q <= 1'b0;
      tree_a_q <= 1'b0;
      tree_b_q <= 1'b0;
      a_bank_q <= 1'b0;
      b_bank_q <= 1'b0;
      iso_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      arm_q <= arm_d;
      len_q <= len_d;
      list_q <= list_d;
      ptr_q <= ptr_d;
      cyc_q <= cyc_d;
      sel_q <= sel_d;
      target_q <= target_d;
      result_q <= result_d;
      done_q <= done_d;
      err_q <= err_d;
      pend_q <= pend_d;
      tree_a_q <= tree_a_d;
      tree_b_q <= tree_b_d;
      a_bank_q <= a_bank_d;
      b_bank_q <= b_bank_d;
      iso_q <= iso_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign tree_a_close = tree_a_q;
  assign tree_b_close = tree_b_q;
  assign tree_a_bank = a_bank_q;
  assign tree_b_bank = b_bank_q;
  assign bank_isolate = iso_q;
  assign scan_done = done_q;

endmodule // css_top
`default_nettype wire

// ### css_pkg.sv
`default_nettype none
package css_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ARM = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_LEN = 8'h0C;
  localparam logic [7:0] ADDR_QUERY = 8'h10;
  localparam logic [7:0] ADDR_RESULT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [1:0] LIST_PAGE = 2'h1;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_ANALOG_BUS_ROUTING = 2;
  localparam int CTRL_FOUR_WIRE_RESISTANCE_MODE = 3;
  localparam int CTRL_CONT = 4;
  localparam int CTRL_TOUT = 5;
  localparam int CMD_INIT = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_CLOSE = 2;
  localparam int CMD_OPEN = 3;
  localparam int CMD_CHAN_LSB = 4;
  localparam int QRY_START_LSB = 0;
  localparam int QRY_END_LSB = 4;
  localparam int QRY_OPEN = 8;
  localparam int STAT_RUN = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_PEND = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_CHAN_LSB = 8;
  localparam int STAT_CLOSED_LSB = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] ARM_RST = 16'h0001;
  localparam logic [4:0] LEN_RST = 5'h10;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int BREAK_NS = 200;
  localparam int BREAK_CYC = (BREAK_NS * CLK_MHZ + 999) / 1000;
  localparam int SELF_PERIOD_NS = 10000;
  localparam int SELF_CYC = (SELF_PERIOD_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_BUS = 2'h1,
    SRC_HANDSHAKE_BUS_SOURCE = 2'h2,
    SRC_IMM = 2'h3
  } css_src_type;

endpackage
`default_nettype wire

// ### css_trig_if.sv
`default_nettype none
interface css_trig_if;
  logic [1:0] src;
  logic trig_out_en;
  logic armed;
  logic sw_trig;
  logic settled;
  logic advance;
  modport ctl (output src, output trig_out_en, output armed, output sw_trig,
               output settled, input advance);
  modport unit (input src, input trig_out_en, input armed, input sw_trig,
                input settled, output advance);
endinterface
`default_nettype wire

// ### css_break_make.sv
`default_nettype none
module css_break_make
  import css_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requested and applied switch state
  input wire logic [CHANNELS-1:0] target,
  output logic [CHANNELS-1:0] applied,
  output logic busy,
  output logic settled
);

  logic [CHANNELS-1:0] applied_q, applied_d;
  logic [7:0] cnt_q, cnt_d;
  logic settled_q, settled_d;

  // ----------------------------------------------------------------------
  // Open everything, wait, then close the new set.
  // ----------------------------------------------------------------------
  always_comb begin
    applied_d = applied_q;
    cnt_d = cnt_q;
    settled_d = 1'b0;
    if (target != applied_q) begin
      if (applied_q != '0) begin
        applied_d = '0;
        cnt_d = 8'(BREAK_CYC);
      end else if (cnt_q != 8'h00) begin
        cnt_d = cnt_q - 8'h01;
      end else begin
        applied_d = target;
        settled_d = (target != '0);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      applied_q <= '0;
      cnt_q <= 8'h00;
      settled_q <= 1'b0;
    end else begin
      applied_q <= applied_d;
      cnt_q <= cnt_d;
      settled_q <= settled_d;
    end
  end

  assign applied = applied_q;
  assign busy = (target != applied_q);
  assign settled = settled_q;

endmodule // css_break_make
`default_nettype wire

// ### css_trig_unit.sv
`default_nettype none
module css_trig_unit
  import css_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  css_trig_if.unit tif,
  // Pins
  input wire logic ext_event,
  input wire logic meas_done,
  output logic trig_out,
  output logic meter_trig
);

  logic [2:0] ext_s_q, meas_s_q;
  logic ext_lvl_q, ext_lvl_d, meas_lvl_q, meas_lvl_d;
  logic [15:0] div_q, div_d;
  logic tout_q, tout_d, mtrig_q, mtrig_d;
  logic tick;

  // ----------------------------------------------------------------------
  // Source selection and pulses.
  // ----------------------------------------------------------------------
  always_comb begin
    ext_lvl_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_lvl_q;
    meas_lvl_d = (meas_s_q[1] == meas_s_q[2]) ? meas_s_q[2] : meas_lvl_q;
    tick = (div_q == 16'h0000);
    div_d = (tif.armed && tif.src == SRC_IMM && !tick) ? div_q - 16'h0001
                                                     : 16'(SELF_CYC - 1);
    tout_d = tif.trig_out_en && tif.settled &&
             (tif.src == SRC_EXT || tif.src == SRC_BUS);
    mtrig_d = tif.settled && tif.src == SRC_HANDSHAKE_BUS_SOURCE;
    tif.advance = 1'b0;
    if (tif.armed) begin
      case (tif.src)
        SRC_EXT: tif.advance = ext_lvl_d && !ext_lvl_q;
        SRC_BUS: tif.advance = tif.sw_trig;
        SRC_HANDSHAKE_BUS_SOURCE: tif.advance = meas_lvl_d && !meas_lvl_q;
        SRC_IMM: tif.advance = tick;
        default: tif.advance = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_s_q <= 3'h0;
      meas_s_q <= 3'h0;
      ext_lvl_q <= 1'b0;
      meas_lvl_q <= 1'b0;
      div_q <= 16'h0000;
      tout_q <= 1'b0;
      mtrig_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], ext_event};
      meas_s_q <= {meas_s_q[1:0], meas_done};
      ext_lvl_q <= ext_lvl_d;
      meas_lvl_q <= meas_lvl_d;
      div_q <= div_d;
      tout_q <= tout_d;
      mtrig_q <= mtrig_d;
    end
  end

  assign trig_out = tout_q;
  assign meter_trig = mtrig_q;

endmodule // css_trig_unit
`default_nettype wire

// ### css_top_assertions.sv
`default_nettype none
module css_top_chk
  import css_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int LIST_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Meter and mainframe pins
  input wire logic ext_event,
  input wire logic meas_done,
  input wire logic trig_out,
  input wire logic meter_trig,
  // Switch drive
  input wire logic [CHANNELS-1:0] chan_close,
  input wire logic tree_a_close,
  input wire logic tree_b_close,
  input wire logic tree_a_bank,
  input wire logic tree_b_bank,
  input wire logic bank_isolate,
  input wire logic scan_done
);
  logic [5:0] ctrl_q;
  logic ctrl_wr;
  assign ctrl_wr = wr && addr == ADDR_CTRL;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= wdata[5:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_one_closed: assert property ($countones(chan_close) <= (bank_isolate ? 2 : 1))
    else $error("too many channels closed");
  chk_break_first: assert property ($changed(chan_close) && $past(chan_close) != '0
    |-> chan_close == '0) else $error("new channel closed before old one opened");
  chk_pair_close: assert property ($rose(|chan_close) && bank_isolate
    |-> chan_close[15:8] == chan_close[7:0]) else $error("partner channel not closed");
  chk_bank_split: assert property ($rose(|chan_close) && bank_isolate
    |-> tree_a_bank != tree_b_bank) else $error("banks not split between trees");
  chk_bank_map: assert property ($rose(|chan_close) && !bank_isolate
    |-> tree_a_bank == |chan_close[15:8]) else $error("closed channel on wrong bank");
  chk_analog_bus_routing_join: assert property (ctrl_wr && wdata[CTRL_ANALOG_BUS_ROUTING]
    |-> ##3 tree_a_close && tree_b_close) else $error("tree switches not closed");
  chk_none_open: assert property (ctrl_wr && !wdata[CTRL_ANALOG_BUS_ROUTING]
    |-> ##3 !tree_a_close && !tree_b_close) else $error("tree switches not opened");
  chk_reset_open: assert property ($fell(rst)
    |-> !tree_a_close && !tree_b_close && chan_close == '0) else $error("reset state wrong");
  chk_trig_src: assert property (trig_out |-> ctrl_q[CTRL_TOUT]
    && ctrl_q[1:0] inside {SRC_EXT, SRC_BUS}) else $error("trigger out from wrong source");
  chk_hs_src: assert property (meter_trig |-> ctrl_q[1:0] == SRC_HANDSHAKE_BUS_SOURCE)
    else $error("meter trigger without handshake source");
  cover property ($rose(scan_done));
  cover property ($rose(|chan_close) && bank_isolate);
  cover property (meter_trig);
  cover property (trig_out);
endmodule // css_top_chk
bind css_top css_top_chk #(.CHANNELS(CHANNELS), .LIST_DEPTH(LIST_DEPTH)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ext_event(ext_event), .meas_done(meas_done), .trig_out(trig_out),
  .meter_trig(meter_trig), .chan_close(chan_close), .tree_a_close(tree_a_close),
  .tree_b_close(tree_b_close), .tree_a_bank(tree_a_bank), .tree_b_bank(tree_b_bank),
  .bank_isolate(bank_isolate), .scan_done(scan_done)
);
`default_nettype wire

// ### css_meter_model.sv
`default_nettype none
module css_meter_model (
  // Clock
  input wire logic clk,
  // Handshake
  input wire logic meter_trig,
  input wire logic slow,
  output logic meas_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Each trigger starts one measurement that ends in a two-cycle completion pulse.
  always @(posedge clk) begin
    if (meter_trig === 1'b1) begin
      cnt <= slow ? 60 : 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign meas_done = cnt == 1 || cnt == 2;
endmodule // css_meter_model
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ext_event = 0, slow = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [15:0] chan_close, prev = '0;
  logic trig_out, meter_trig, tree_a_close, tree_b_close, tree_a_bank, tree_b_bank;
  logic bank_isolate, scan_done, meas_done;
  int errors = 0, checks = 0, ntrig = 0, nclose = 0;
  int lst[4];
  css_top #(.CHANNELS(16), .LIST_DEPTH(16)) uut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_event(ext_event), .meas_done(meas_done), .trig_out(trig_out),
    .meter_trig(meter_trig), .chan_close(chan_close), .tree_a_close(tree_a_close),
    .tree_b_close(tree_b_close), .tree_a_bank(tree_a_bank), .tree_b_bank(tree_b_bank),
    .bank_isolate(bank_isolate), .scan_done(scan_done)
  );
  css_meter_model meter (.clk(clk), .meter_trig(meter_trig), .slow(slow),
    .meas_done(meas_done));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (trig_out === 1'b1) ntrig++;
    if (chan_close !== 16'h0 && prev === 16'h0) nclose++;
    prev = chan_close;
  end
  function automatic logic [15:0] one(input int c);
    return 16'h1 << c;
  endfunction
  task automatic complete_run;
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_chan(input logic [15:0] e);
    int i;
    for (i = 0; i < 3000 && chan_close !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk("chan_close", e, chan_close);
    if (i == 3000) complete_run();
  endtask
  initial begin
    int n;
    int b;
    int k;
    void'($urandom(32538));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg(ADDR_CTRL, got);
    chk("ctrl", 32'h0, got);
    rreg(ADDR_ARM, got);
    chk("arm", 32'h1, got);
    rreg(ADDR_LEN, got);
    chk("len", 32'h10, got);
    rreg(8'hFC, got);
    chk("unmapped", 32'h0, got);
    chk("tree", 32'h0, tree_a_close | tree_b_close);
    wreg(ADDR_CTRL, 32'h04);
    wreg(ADDR_CMD, 32'h24);
    wait_chan(one(2));
    chk("tree", 32'h1, tree_a_close & tree_b_close);
    wreg(ADDR_CMD, 32'h94);
    wait_chan(one(9));
    chk("bank_a", 32'h1, tree_a_bank);
    wreg(ADDR_QUERY, 32'hF0);
    rreg(ADDR_RESULT, got);
    chk("result", one(9), got);
    wreg(ADDR_QUERY, 32'h1F0);
    rreg(ADDR_RESULT, got);
    chk("result", 32'hFDFF, got);
    wreg(ADDR_QUERY, 32'hB8);
    rreg(ADDR_RESULT, got);
    chk("result", 32'h2, got);
    wreg(ADDR_QUERY, 32'hF0);
    wreg(ADDR_CMD, 32'h2);
    rreg(ADDR_STATUS, got);
    chk("error", 32'h1, got[STAT_ERR]);
    rreg(ADDR_RESULT, got);
    wreg(ADDR_STATUS, 32'h4);
    rreg(ADDR_STATUS, got);
    chk("error", 32'h0, got[STAT_ERR]);
    wreg(ADDR_CMD, 32'h98);
    wait_chan(16'h0);
    wreg(ADDR_CTRL, 32'h0C);
    wreg(ADDR_CMD, 32'h24);
    wait_chan(one(2) | one(10));
    chk("banks", 32'h5, {bank_isolate, tree_a_bank, tree_b_bank});
    wreg(ADDR_CMD, 32'hF4);
    wait_chan(one(15) | one(7));
    chk("bank_a", 32'h1, tree_a_bank);
    wreg(ADDR_CMD, 32'hF8);
    wait_chan(16'h0);
    b = $urandom % 16;
    k = 1 + $urandom % 5;
    for (n = 0; n < 4; n++) begin
      lst[n] = (b + n * k) % 16;
      wreg(8'h40 + 8'(4 * n), 32'(lst[n]));
    end
    wreg(ADDR_CTRL, 32'h25);
    wreg(ADDR_LEN, 32'h3);
    wreg(ADDR_ARM, 32'h2);
    ntrig = 0;
    nclose = 0;
    for (n = 0; n < 6; n++) begin
      wreg(ADDR_CMD, (n == 0 || n == 3) ? 32'h1 : 32'h2);
      wait_chan(one(lst[n % 3]));
      repeat (3) @(posedge clk);
    end
    rreg(ADDR_STATUS, got);
    chk("done", 32'h1, got[STAT_DONE]);
    chk("trig_out", 32'h6, ntrig);
    chk("closes", 32'h6, nclose);
    wreg(ADDR_CMD, 32'h2);
    repeat (30) @(posedge clk);
    #1;
    chk("chan_close", one(lst[2]), chan_close);
    wreg(ADDR_CTRL, 32'h20);
    wreg(ADDR_LEN, 32'h2);
    wreg(ADDR_ARM, 32'h1);
    wreg(ADDR_CMD, 32'h1);
    wait_chan(one(lst[0]));
    chk("tree", 32'h0, tree_a_close | tree_b_close);
    wreg(ADDR_CMD, 32'h2);
    repeat (40) @(posedge clk);
    #1;
    chk("chan_close", one(lst[0]), chan_close);
    @(posedge clk);
    ext_event <= 1'b1;
    repeat (3) @(posedge clk);
    ext_event <= 1'b0;
    wait_chan(one(lst[1]));
    wreg(ADDR_CTRL, 32'h02);
    wreg(ADDR_LEN, 32'h4);
    wreg(ADDR_ARM, 32'h5);
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      nclose = 0;
      wreg(ADDR_CMD, 32'h1);
      for (n = 0; n < 4; n++) wait_chan(one(lst[n]));
      repeat (3) @(posedge clk);
      rreg(ADDR_STATUS, got);
      chk("done", 32'h1, got[STAT_DONE]);
      chk("closes", 32'h4, nclose);
    end
    wreg(ADDR_CTRL, 32'h13);
    wreg(ADDR_LEN, 32'h2);
    nclose = 0;
    wreg(ADDR_CMD, 32'h1);
    repeat (2500) @(posedge clk);
    #1;
    chk("done", 32'h0, scan_done);
    chk("cycles", 32'h1, nclose >= 4);
    wreg(ADDR_CTRL, 32'h03);
    for (n = 0; n < 2000 && scan_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 32'h1, scan_done);
    complete_run();
  end
endmodule // tb
`default_nettype wire
